// file: include/hot_swap_map.vh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   definitions only
`ifndef HOT_SWAP_MAP_VH
`define HOT_SWAP_MAP_VH

// register word indices (byte address is index times four)
`define ADC_RESULT_IDX      8'h00
`define ADC_CTRL_IDX        8'h01
`define CTRL_A_IDX          8'h02
`define CTRL_B_IDX          8'h03
`define STAT_A_IDX          8'h04
`define STAT_B_IDX          8'h05
`define STAT_COMMON_IDX     8'h06
`define DELAY_CFG_IDX       8'h07
`define IDX_TO_ADDR(i)      ((i) << 2)

// slot control fields
`define CTRL_MAIN_BIT       0
`define CTRL_AUX_BIT        1

// slot status fields
`define ST_MAIN_OC          0
`define ST_MAIN_FAST        1
`define ST_MAIN_UV          2
`define ST_AUX_OC           3
`define ST_LOCAL_OT         4
`define ST_WIDTH            5

// common status fields
`define CS_DIE_OT           0
`define CS_INT_MASK         1

// adc control fields
`define ADC_SUP_LO          0
`define ADC_SUP_HI          2
`define ADC_PAR_BIT         3
`define ADC_SEL_BIT         4
`define ADC_BUSY_BIT        7

// reset values
`define RST_BYTE            8'h00
`define RST_DELAY           16'h0FA0

// standby qualification: 500 us at 125 MHz (8 ns period)
`define QUAL_TIME_NS        500000
`define CLK_PERIOD_NS       8
`define QUAL_CYCLES         (`QUAL_TIME_NS / `CLK_PERIOD_NS)
`define ADC_CONV_CYCLES     16'h0040

`endif

// file: logic/hot_swap_ctrl.v
// Purpose: dual-slot hot-swap fault control with apb registers
// Assumes: analog comparators arrive as asynchronous level inputs
// Notes:   adc converter itself is outside; this block sequences it
// What this block does
// - gate drives for 3.3V and 5V stay low while slot disabled
// - enabled slot with no undervoltage turns its main supplies on
// - switched-off slot closes its output discharge switches
// - standby entered when any main enable is on and any undervoltage input is set
// - aux output follows its pin or bit, independent of main
// - undervoltage with main enable still on asserts fault and irq
// - overcurrent longer than fault delay trips main breaker
// - fast-trip overcurrent turns mains off at once
// - undervoltage trips breaker only while mains enabled
// - aux breaker has no fast trip, trips after fault delay
// - toggling control register enable bits clears a latched fault
// - slot fault pin asserts on trip in pin-controlled mode, and on local overtemp or undervoltage in any mode
// - local overtemperature turns off whole slot, asserts its fault
// - die overtemperature turns off both slots, sets common flag
// - measurement converter result readable over the bus
// - irq output low on breaker trip unless masked
// - each fault event sets a sticky status bit
// - slot status bit clears only on write of one
// - irq released after clear if nothing else pending
// - reset releases after standby supply valid for 500 us
`timescale 1ns/100ps
`default_nettype none
`include "hot_swap_map.vh"
module hot_swap_ctrl #(
  parameter [31:0] QUAL_CYCLES = `QUAL_CYCLES
) (
  // clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,

  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,

  // pin power interface
  input  wire [1:0]  main_power_pin,
  input  wire [1:0]  standby_output_request_pin,
  output wire [1:0]  slot_fault_n,
  output wire        irq_n,

  // supply and sense comparators
  input  wire        standby_supply_input,
  input  wire [3:0]  undervoltage_lockout,
  input  wire [1:0]  main_overcurrent,
  input  wire [1:0]  fast_trip_sense_level,
  input  wire [1:0]  standby_overcurrent,
  input  wire [1:0]  slot_overtemp,
  input  wire        die_overtemp,

  // converter interface
  output reg         adc_start,
  output reg  [4:0]  adc_channel,
  input  wire [7:0]  adc_data,

  // power outputs
  output wire [1:0]  gate_3v_on,
  output wire [1:0]  gate_5v_on,
  output wire [1:0]  main_on,
  output wire [1:0]  standby_output,
  output wire [1:0]  discharge_on,
  output wire        standby_mode
);
  wire [11:0] raw_in;
  wire [11:0] sync_in;
  wire [3:0]  uv_sync;

  wire [1:0]  mpin;
  wire [1:0]  apin;

  wire [1:0]  moc;
  wire [1:0]  mfast;
  wire [1:0]  aoc;
  wire [1:0]  lot;
  wire        dot;
  wire        stby_ok;
  wire        uv_any;

  wire [1:0]  mreq;
  wire [`ST_WIDTH-1:0] stat_a;
  wire [`ST_WIDTH-1:0] stat_b;
  wire [`ST_WIDTH-1:0] clr_a;
  wire [`ST_WIDTH-1:0] clr_b;
  wire        pend;

  wire        wr;
  wire        rd;

  reg  [31:0] qual_cnt_q;
  reg         run_q;

  reg  [7:0]  ctrl_a_q;
  reg  [7:0]  ctrl_b_q;
  reg  [7:0]  adc_ctrl_q;
  reg  [7:0]  adc_result_q;
  reg  [15:0] adc_cnt_q;
  reg  [15:0] delay_q;
  reg         die_ot_q;
  reg         mask_q;

  assign raw_in = {die_overtemp, standby_supply_input, slot_overtemp,
                   standby_overcurrent, fast_trip_sense_level,
                   main_overcurrent, standby_output_request_pin};
  genvar g;

  generate
    for (g = 0; g < 12; g = g + 1) begin : g_sync
      sync3 u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (raw_in[g]),
        .q       (sync_in[g])
      );
    end

    for (g = 0; g < 4; g = g + 1) begin : g_uv
      sync3 u_uv (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (undervoltage_lockout[g]),
        .q       (uv_sync[g])
      );
    end

    for (g = 0; g < 2; g = g + 1) begin : g_pin
      sync3 u_pin (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (main_power_pin[g]),
        .q       (mpin[g])
      );
    end
  endgenerate

  assign apin    = sync_in[1:0];
  assign moc     = sync_in[3:2];
  assign mfast   = sync_in[5:4];
  assign aoc     = sync_in[7:6];
  assign lot     = sync_in[9:8];
  assign stby_ok = sync_in[10];
  assign dot     = sync_in[11];

  assign uv_any  = |uv_sync;

  // standby supply qualification gates all slot logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_cnt_q <= 32'h00000000;
      run_q      <= 1'b0;
    end else if (ce) begin
      if (!stby_ok) begin
        qual_cnt_q <= 32'h00000000;
        run_q      <= 1'b0;
      end else if (qual_cnt_q >= QUAL_CYCLES) begin
        run_q <= 1'b1;
      end else begin
        qual_cnt_q <= qual_cnt_q + 32'h00000001;
      end
    end
  end

  assign standby_mode = |(mreq) & uv_any;

  // apb: zero wait states, no error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  assign clr_a = (wr && paddr == `IDX_TO_ADDR(`STAT_A_IDX)) ?
                 pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  assign clr_b = (wr && paddr == `IDX_TO_ADDR(`STAT_B_IDX)) ?
                 pwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}};

  // registers; power-on qualification loss clears all but result and slot status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q   <= `RST_BYTE;
      ctrl_b_q   <= `RST_BYTE;
      adc_ctrl_q <= `RST_BYTE;
      delay_q    <= `RST_DELAY;
      die_ot_q   <= 1'b0;
      mask_q     <= 1'b0;
      prdata     <= 32'h00000000;
    end else if (ce) begin
      if (!run_q) begin
        ctrl_a_q   <= `RST_BYTE;
        ctrl_b_q   <= `RST_BYTE;
        adc_ctrl_q <= `RST_BYTE;
        delay_q    <= `RST_DELAY;
        die_ot_q   <= 1'b0;
        mask_q     <= 1'b0;
      end else begin
        if (wr) begin
          case (paddr)
            `IDX_TO_ADDR(`CTRL_A_IDX): ctrl_a_q <= pwdata[7:0];
            `IDX_TO_ADDR(`CTRL_B_IDX): ctrl_b_q <= pwdata[7:0];
            `IDX_TO_ADDR(`ADC_CTRL_IDX):
              adc_ctrl_q <= {1'b0, 2'b00, pwdata[4:0]};
            `IDX_TO_ADDR(`DELAY_CFG_IDX): delay_q <= pwdata[15:0];
            `IDX_TO_ADDR(`STAT_COMMON_IDX):
              mask_q <= pwdata[`CS_INT_MASK];
            default: ;
          endcase
        end

        // die flag: set wins over a write-one clear
        if (dot) begin
          die_ot_q <= 1'b1;
        end else if (wr && paddr == `IDX_TO_ADDR(`STAT_COMMON_IDX)
                     && pwdata[`CS_DIE_OT]) begin
          die_ot_q <= 1'b0;
        end
      end

      if (rd) begin
        case (paddr)
          `IDX_TO_ADDR(`ADC_RESULT_IDX):
            prdata <= {24'h000000, adc_result_q};
          `IDX_TO_ADDR(`ADC_CTRL_IDX):
            prdata <= {24'h000000, adc_ctrl_q[7:5] | {(|adc_cnt_q), 2'b00},
                       adc_ctrl_q[4:0]};
          `IDX_TO_ADDR(`CTRL_A_IDX):  prdata <= {24'h000000, ctrl_a_q};
          `IDX_TO_ADDR(`CTRL_B_IDX):  prdata <= {24'h000000, ctrl_b_q};
          `IDX_TO_ADDR(`STAT_A_IDX):  prdata <= {27'h0000000, stat_a};
          `IDX_TO_ADDR(`STAT_B_IDX):  prdata <= {27'h0000000, stat_b};
          `IDX_TO_ADDR(`STAT_COMMON_IDX):
            prdata <= {30'h00000000, mask_q, die_ot_q};
          `IDX_TO_ADDR(`DELAY_CFG_IDX): prdata <= {16'h0000, delay_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // converter sequencing: a write with nonzero supply starts one conversion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_cnt_q    <= 16'h0000;
      adc_start    <= 1'b0;
      adc_channel  <= 5'h00;
      adc_result_q <= 8'h00;
    end else if (ce) begin
      adc_start <= 1'b0;

      if (run_q && wr && paddr == `IDX_TO_ADDR(`ADC_CTRL_IDX)
          && pwdata[`ADC_SUP_HI:`ADC_SUP_LO] != 3'b000) begin
        adc_cnt_q   <= `ADC_CONV_CYCLES;
        adc_start   <= 1'b1;
        adc_channel <= pwdata[4:0];
      end else if (adc_cnt_q != 16'h0000) begin
        adc_cnt_q <= adc_cnt_q - 16'h0001;
        if (adc_cnt_q == 16'h0001) begin
          adc_result_q <= adc_data;
        end
      end
    end
  end

  // two slots share one breaker module
  slot_breaker u_slot_a (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce & run_q),

    .main_pin  (mpin[0]),
    .aux_pin   (apin[0]),
    .main_bit  (ctrl_a_q[`CTRL_MAIN_BIT]),
    .aux_bit   (ctrl_a_q[`CTRL_AUX_BIT]),
    .delay_cfg (delay_q),
    .uv_any    (uv_any),

    .main_oc   (moc[0]),
    .main_fast (mfast[0]),
    .aux_oc    (aoc[0]),
    .local_ot  (lot[0]),
    .die_ot    (dot),
    .clr       (clr_a),

    .gate_3v   (gate_3v_on[0]),
    .gate_5v   (gate_5v_on[0]),
    .main_on   (main_on[0]),
    .aux_on    (standby_output[0]),
    .discharge (discharge_on[0]),
    .fault_n   (slot_fault_n[0]),
    .stat_q    (stat_a),
    .main_req  (mreq[0])
  );

  slot_breaker u_slot_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce & run_q),

    .main_pin  (mpin[1]),
    .aux_pin   (apin[1]),
    .main_bit  (ctrl_b_q[`CTRL_MAIN_BIT]),
    .aux_bit   (ctrl_b_q[`CTRL_AUX_BIT]),
    .delay_cfg (delay_q),
    .uv_any    (uv_any),

    .main_oc   (moc[1]),
    .main_fast (mfast[1]),
    .aux_oc    (aoc[1]),
    .local_ot  (lot[1]),
    .die_ot    (dot),
    .clr       (clr_b),

    .gate_3v   (gate_3v_on[1]),
    .gate_5v   (gate_5v_on[1]),
    .main_on   (main_on[1]),
    .aux_on    (standby_output[1]),
    .discharge (discharge_on[1]),
    .fault_n   (slot_fault_n[1]),
    .stat_q    (stat_b),
    .main_req  (mreq[1])
  );

  // irq low while any sticky bit pends and not masked
  assign pend  = (|stat_a) | (|stat_b) | die_ot_q;
  assign irq_n = ~(~mask_q & pend);
  // releases once the last pending bit is cleared
endmodule
`default_nettype wire

// file: logic/slot_breaker.v
// Purpose: one slot's breakers, enables, gate, discharge and status bits
// Assumes: sense inputs already synchronised
// Notes:   trips latch until the matching enable is cycled
`timescale 1ns/100ps
`default_nettype none
`include "hot_swap_map.vh"
module slot_breaker (
  // clock and reset
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   ce,
  // enables
  input  wire                   main_pin,
  input  wire                   aux_pin,
  input  wire                   main_bit,
  input  wire                   aux_bit,
  input  wire [15:0]            delay_cfg,
  // sense
  input  wire                   uv_any,
  input  wire                   main_oc,
  input  wire                   main_fast,
  input  wire                   aux_oc,
  input  wire                   local_ot,
  input  wire                   die_ot,
  // status clear
  input  wire [`ST_WIDTH-1:0]   clr,
  // outputs
  output reg                    gate_3v,
  output reg                    gate_5v,
  output reg                    main_on,
  output reg                    aux_on,
  output reg                    discharge,
  output reg                    fault_n,
  output reg  [`ST_WIDTH-1:0]   stat_q,
  output wire                   main_req
);
  reg  [15:0]          main_cnt_q;
  reg  [15:0]          aux_cnt_q;
  reg                  main_trip_q;
  reg                  aux_trip_q;
  reg                  main_req_q;
  reg                  aux_req_q;
  wire                 aux_req;
  wire                 main_cycle;
  wire                 aux_cycle;
  wire                 oc_expire;
  wire                 aux_expire;
  wire                 uv_trip;
  wire                 main_trip_ev;
  wire                 aux_trip_ev;
  reg  [`ST_WIDTH-1:0] ev;

  assign main_req   = main_pin | main_bit;
  assign aux_req    = aux_pin | aux_bit;
  assign main_cycle = main_req_q & ~main_req;
  assign aux_cycle  = aux_req_q & ~aux_req;
  assign oc_expire  = main_on & main_oc & (main_cnt_q >= delay_cfg);
  assign aux_expire = aux_on & aux_oc & (aux_cnt_q >= delay_cfg);
  assign uv_trip    = main_req & uv_any;
  assign main_trip_ev = oc_expire | (main_on & main_fast) | uv_trip
                      | local_ot | die_ot;
  assign aux_trip_ev  = aux_expire | local_ot | die_ot;

  always @* begin
    ev = {`ST_WIDTH{1'b0}};
    ev[`ST_MAIN_OC]   = oc_expire;
    ev[`ST_MAIN_FAST] = main_on & main_fast;
    ev[`ST_MAIN_UV]   = uv_trip;
    ev[`ST_AUX_OC]    = aux_expire;
    ev[`ST_LOCAL_OT]  = local_ot;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_cnt_q  <= 16'h0000;
      aux_cnt_q   <= 16'h0000;
      main_trip_q <= 1'b0;
      aux_trip_q  <= 1'b0;
      main_req_q  <= 1'b0;
      aux_req_q   <= 1'b0;
      stat_q      <= {`ST_WIDTH{1'b0}};
      fault_n     <= 1'b1;
      main_on     <= 1'b0;
      aux_on      <= 1'b0;
      gate_3v     <= 1'b0;
      gate_5v     <= 1'b0;
      discharge   <= 1'b1;
    end else if (ce) begin
      main_req_q <= main_req;
      aux_req_q  <= aux_req;
      // fault delay restarts when overcurrent goes away
      if (main_on & main_oc) begin
        main_cnt_q <= main_cnt_q + 16'h0001;
      end else begin
        main_cnt_q <= 16'h0000;
      end
      if (aux_on & aux_oc) begin
        aux_cnt_q <= aux_cnt_q + 16'h0001;
      end else begin
        aux_cnt_q <= 16'h0000;
      end
      // latch until the enable is cycled
      if (main_trip_ev) begin
        main_trip_q <= 1'b1;
      end else if (main_cycle) begin
        main_trip_q <= 1'b0;
      end
      if (aux_trip_ev) begin
        aux_trip_q <= 1'b1;
      end else if (aux_cycle) begin
        aux_trip_q <= 1'b0;
      end
      // set wins over clear
      stat_q <= (stat_q & ~clr) | ev;
      if (((main_trip_ev | aux_trip_ev) & (main_pin | aux_pin))
          | local_ot | uv_trip) begin
        fault_n <= 1'b0;
      end else if ((main_cycle | aux_cycle) & ~main_req & ~aux_req) begin
        fault_n <= 1'b1;
      end
      main_on   <= main_req & ~main_trip_q & ~main_trip_ev
                 & ~uv_any;
      aux_on    <= aux_req & ~aux_trip_q & ~aux_trip_ev;
      gate_3v   <= main_req & ~main_trip_q & ~main_trip_ev
                 & ~uv_any;
      gate_5v   <= main_req & ~main_trip_q & ~main_trip_ev & ~uv_any;
      discharge <= ~(main_req & ~main_trip_q & ~main_trip_ev & ~uv_any)
                 & ~(aux_req & ~aux_trip_q & ~aux_trip_ev);
    end
  end
endmodule
`default_nettype wire

// file: logic/sync3.v
// Purpose: three-stage synchroniser, change taken when stages 2 and 3 agree
// Assumes: asynchronous input
// Notes:   stage one feeds stage two only
`timescale 1ns/100ps
`default_nettype none
module sync3 (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  // data
  input  wire d,
  output reg  q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q    <= 1'b0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/dual_slot_hot_swap_fault_control_tb.sv
// Purpose: register and pin level tests of hot_swap_ctrl
// Assumes: short qualification count in simulation
// Notes:   slot vectors {irq_n,standby,fault_n,aux,main,gate5,gate3}
`timescale 1ns/100ps
`default_nettype none
`include "hot_swap_map.vh"
module dual_slot_hot_swap_fault_control_tb;
  localparam logic [7:0] AR = `ADC_RESULT_IDX * 4;
  localparam logic [7:0] AC = `ADC_CTRL_IDX * 4;
  localparam logic [7:0] CA = `CTRL_A_IDX * 4;
  localparam logic [7:0] SA = `STAT_A_IDX * 4;
  localparam logic [7:0] SB = `STAT_B_IDX * 4;
  localparam logic [7:0] CO = `STAT_COMMON_IDX * 4;
  localparam logic [7:0] DL = `DELAY_CFG_IDX * 4;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv;
  logic [1:0]  main_power_pin = 2'b00, standby_output_request_pin = 2'b00;
  logic [1:0]  slot_overtemp = 2'b00, short_req = 2'b00;
  logic [1:0]  fast_req = 2'b00, aux_short_req = 2'b00;
  logic [3:0]  undervoltage_lockout = 4'h0;
  logic        standby_supply_input = 1'b0, die_overtemp = 1'b0;
  wire         pready, pslverr, irq_n, standby_mode, adc_start;
  wire [31:0]  prdata;
  wire [1:0]   slot_fault_n, gate_3v_on, gate_5v_on, main_on;
  wire [1:0]   standby_output, discharge_on, main_overcurrent;
  wire [1:0]   fast_trip_sense_level, standby_overcurrent;
  wire [4:0]   adc_channel;
  wire [7:0]   adc_data;
  wire [31:0]  sa = {25'h0, irq_n, standby_mode, slot_fault_n[0],
                     standby_output[0], main_on[0], gate_5v_on[0],
                     gate_3v_on[0]};
  wire [31:0]  sb = {25'h0, irq_n, standby_mode, slot_fault_n[1],
                     standby_output[1], main_on[1], gate_5v_on[1],
                     gate_3v_on[1]};
  int          miscompares = 0, checks_done = 0;
  always #4 pclk = ~pclk;
  hot_swap_ctrl #(.QUAL_CYCLES(32'd10)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .main_power_pin(main_power_pin),
    .standby_output_request_pin(standby_output_request_pin),
    .slot_fault_n(slot_fault_n), .irq_n(irq_n),
    .standby_supply_input(standby_supply_input),
    .undervoltage_lockout(undervoltage_lockout),
    .main_overcurrent(main_overcurrent),
    .fast_trip_sense_level(fast_trip_sense_level),
    .standby_overcurrent(standby_overcurrent),
    .slot_overtemp(slot_overtemp), .die_overtemp(die_overtemp),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_data(adc_data), .gate_3v_on(gate_3v_on),
    .gate_5v_on(gate_5v_on), .main_on(main_on),
    .standby_output(standby_output), .discharge_on(discharge_on),
    .standby_mode(standby_mode)
  );
  slot_board_model board (
    .pclk(pclk), .presetn(presetn), .short_req(short_req),
    .fast_req(fast_req), .aux_short_req(aux_short_req),
    .main_on(main_on), .standby_output(standby_output),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .main_overcurrent(main_overcurrent),
    .fast_trip_sense_level(fast_trip_sense_level),
    .standby_overcurrent(standby_overcurrent), .adc_data(adc_data)
  );
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic results;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    results();
  end
  initial begin
    cy(5);
    presetn <= 1'b1;
    standby_supply_input <= 1'b1;
    cy(1);
    apb(1'b1, DL, 32'd20);
    for (int i = 1; i < 9; i++)
      rd(8'(i * 4), (i == 7) ? 32'h0FA0 : 32'h0);
    chk(sa, 32'h50);
    chk({30'h0, pready, pslverr}, 32'h2);
    cy(10);
    apb(1'b1, DL, 32'd20);
    apb(1'b1, CA, 32'h3);
    cy(8);
    chk(sa, 32'h5F);
    short_req <= 2'b01;
    cy(10);
    short_req <= 2'b00;
    cy(8);
    chk(sa, 32'h5F);
    short_req <= 2'b01;
    cy(40);
    short_req <= 2'b00;
    chk(sa, 32'h18);
    rd(SA, 32'h1);
    apb(1'b1, SA, 32'h0);
    rd(SA, 32'h1);
    apb(1'b1, SA, 32'h1);
    rd(SA, 32'h0);
    chk(sa, 32'h58);
    apb(1'b1, CA, 32'h2);
    apb(1'b1, CA, 32'h3);
    cy(8);
    chk(sa, 32'h5F);
    fast_req <= 2'b01;
    cy(8);
    fast_req <= 2'b00;
    chk(sa, 32'h18);
    rd(SA, 32'h2);
    apb(1'b1, SA, 32'h2);
    apb(1'b1, CA, 32'h2);
    apb(1'b1, CA, 32'h3);
    apb(1'b1, CO, 32'h2);
    aux_short_req <= 2'b01;
    cy(12);
    chk({31'h0, standby_output[0]}, 32'h1);
    cy(30);
    aux_short_req <= 2'b00;
    chk(sa, 32'h57);
    rd(SA, 32'h8);
    apb(1'b1, SA, 32'h8);
    apb(1'b1, CO, 32'h0);
    rd(CO, 32'h0);
    apb(1'b1, CA, 32'h0);
    cy(8);
    chk(sa, 32'h50);
    chk({31'h0, discharge_on[0]}, 32'h1);
    undervoltage_lockout <= 4'h1;
    cy(10);
    chk(sa, 32'h50);
    rd(SA, 32'h0);
    undervoltage_lockout <= 4'h0;
    main_power_pin <= 2'b10;
    cy(8);
    chk(sb, 32'h57);
    undervoltage_lockout <= 4'h2;
    cy(10);
    chk(sb, 32'h20);
    rd(SB, 32'h4);
    undervoltage_lockout <= 4'h0;
    main_power_pin <= 2'b00;
    cy(8);
    apb(1'b1, SB, 32'h4);
    chk(sb, 32'h50);
    apb(1'b1, CA, 32'h2);
    main_power_pin <= 2'b10;
    standby_output_request_pin <= 2'b10;
    cy(8);
    chk(sb, 32'h5F);
    slot_overtemp <= 2'b10;
    cy(8);
    chk({29'h0, slot_fault_n[1], sb[3:2]}, 32'h0);
    chk({31'h0, standby_output[0]}, 32'h1);
    rd(SB, 32'h10);
    apb(1'b1, AC, 32'h19);
    cy(2);
    apb(1'b0, AC, 32'h0);
    while (rdv[7] === 1'b1) apb(1'b0, AC, 32'h0);
    chk(rdv, 32'h19);
    rd(AR, 32'hB9);
    die_overtemp <= 1'b1;
    cy(8);
    chk({28'h0, main_on, standby_output}, 32'h0);
    rd(CO, 32'h1);
    results();
  end
endmodule
`default_nettype wire

// file: verif/hot_swap_props.sv
// Purpose: port-level checks for hot_swap_ctrl
// Assumes: sense inputs held steady while a scenario runs
// Notes:   bind follows the module
`timescale 1ns/100ps
`default_nettype none
module hot_swap_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  // sense
  input wire logic [3:0]  undervoltage_lockout,
  input wire logic [1:0]  fast_trip_sense_level,
  input wire logic [1:0]  standby_overcurrent,
  input wire logic [1:0]  slot_overtemp,
  input wire logic        die_overtemp,
  // outputs
  input wire logic [1:0]  gate_3v_on,
  input wire logic [1:0]  gate_5v_on,
  input wire logic [1:0]  main_on,
  input wire logic [1:0]  standby_output,
  input wire logic [1:0]  discharge_on,
  input wire logic [1:0]  slot_fault_n,
  input wire logic        standby_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_gate_low;
    (discharge_on & (gate_3v_on | gate_5v_on)) == 2'b00;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("gate driven while slot discharging");
  property p_off_dis;
    $fell(main_on[0] | standby_output[0]) |-> ##[0:2] discharge_on[0];
  endproperty
  a_off_dis: assert property (p_off_dis)
    else $error("no discharge after turn-off");
  property p_fast;
    $rose(fast_trip_sense_level[0]) && main_on[0] |-> ##[1:8] !main_on[0];
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast trip too slow");
  property p_aux_keep;
    $rose(fast_trip_sense_level[0]) && standby_output[0] && !die_overtemp
      && !slot_overtemp[0] && !standby_overcurrent[0]
      |-> standby_output[0] [*8];
  endproperty
  a_aux_keep: assert property (p_aux_keep)
    else $error("aux dropped on main fast trip");
  property p_local;
    $rose(slot_overtemp[1]) && standby_output[1]
      |-> ##[1:8] !standby_output[1] && !main_on[1] && !slot_fault_n[1];
  endproperty
  a_local: assert property (p_local)
    else $error("local overtemp did not shut slot");
  property p_die;
    die_overtemp |-> ##[1:8] (main_on | standby_output) == 2'b00;
  endproperty
  a_die: assert property (p_die)
    else $error("die overtemp left outputs on");
  property p_prd;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_prd: assert property (p_prd)
    else $error("read data changed outside read");
  property p_stby;
    (undervoltage_lockout == 4'h0) [*8] |-> !standby_mode;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby without undervoltage");
  c_fast: cover property ($rose(fast_trip_sense_level[0]) && main_on[0]);
  c_local: cover property ($rose(slot_overtemp[1]) && standby_output[1]);
  c_die: cover property ($rose(die_overtemp));
endmodule
bind hot_swap_ctrl hot_swap_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata),
  .undervoltage_lockout(undervoltage_lockout),
  .fast_trip_sense_level(fast_trip_sense_level),
  .standby_overcurrent(standby_overcurrent),
  .slot_overtemp(slot_overtemp), .die_overtemp(die_overtemp),
  .gate_3v_on(gate_3v_on), .gate_5v_on(gate_5v_on), .main_on(main_on),
  .standby_output(standby_output), .discharge_on(discharge_on),
  .slot_fault_n(slot_fault_n), .standby_mode(standby_mode)
);
`default_nettype wire

// file: verif/slot_board_model.sv
// Purpose: two plug-in boards and the measurement converter
// Assumes: bench raises fault requests by non-blocking assignment
// Notes:   loads draw current only while powered
`timescale 1ns/100ps
`default_nettype none
module slot_board_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // scenario requests
  input  wire logic [1:0] short_req,
  input  wire logic [1:0] fast_req,
  input  wire logic [1:0] aux_short_req,
  // from controller
  input  wire logic [1:0] main_on,
  input  wire logic [1:0] standby_output,
  input  wire logic       adc_start,
  input  wire logic [4:0] adc_channel,
  // to controller
  output wire logic [1:0] main_overcurrent,
  output wire logic [1:0] fast_trip_sense_level,
  output wire logic [1:0] standby_overcurrent,
  output var  logic [7:0] adc_data
);
  assign main_overcurrent      = short_req & main_on;
  assign fast_trip_sense_level = fast_req & main_on;
  assign standby_overcurrent   = aux_short_req & standby_output;
  // result carries the channel so each conversion is recognisable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      adc_data <= 8'h5A;
    else if (adc_start)
      adc_data <= {3'b101, adc_channel};
  end
endmodule
`default_nettype wire
